// >>> core/ivec_pkg.sv
package ivec_pkg;
  localparam int NUM_SRC = 38;
  localparam int NUM_EVT = 9;
  localparam int NUM_SW = 7;
  localparam int NUM_HWT = 5;
  localparam int NUM_TRAP = 16;
  localparam int NUM_PREG = 6;
  localparam int NUM_MASKABLE = NUM_EVT + NUM_SW;
  localparam int PRIO_W = 4;

  localparam int CODE_RESET = 0;
  localparam int CODE_HWT = 1;
  localparam int CODE_TRAP = 6;
  localparam int CODE_EVT = 22;
  localparam int CODE_SW = 31;

  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_HWT_BASE = 16'h0004;
  localparam logic [15:0] VEC_TRAP_BASE = 16'h0040;
  localparam logic [15:0] VEC_SW_BASE = 16'h0100;
  localparam int VEC_STEP = 4;
  // Event order is also arbitration order, rank 2 first
  localparam logic [NUM_EVT-1:0][15:0] EVT_VEC = {16'h00ac, 16'h00a8,
    16'h00a4, 16'h00a0, 16'h0090, 16'h008c, 16'h0088, 16'h0084,
    16'h0080};
  localparam logic [NUM_EVT-1:0][2:0] EVT_PREG = {3'h5, 3'h5, 3'h4,
    3'h4, 3'h2, 3'h1, 3'h1, 3'h0, 3'h0};
  localparam logic [NUM_EVT-1:0] EVT_PHI = 9'h14a;
  localparam int PRIO_LO_LSB = 0;
  localparam int PRIO_HI_LSB = 4;
  localparam int GIE_BIT = 7;
  localparam int EVT_TIMER2 = 4;
  localparam int EVT_EXT0 = 0;
  localparam int EVT_EXT1 = 2;

  localparam logic [7:0] OFF_EN_LO = 8'h00;
  localparam logic [7:0] OFF_EN_HI = 8'h04;
  localparam logic [7:0] OFF_PRIO0 = 8'h08;
  localparam logic [7:0] OFF_PRIO5 = 8'h1c;
  localparam logic [7:0] OFF_SW_REQ = 8'h20;
  localparam logic [7:0] OFF_SW_EN = 8'h24;
  localparam logic [7:0] OFF_LEVEL = 8'h28;
  localparam logic [7:0] OFF_STAT = 8'h2c;
  localparam logic [7:0] OFF_MASK = 8'h30;
  localparam logic [7:0] OFF_VEC = 8'h34;

  localparam logic [7:0] EN_HI_MASK = 8'h0f;
  localparam logic [7:0] PRIO_MASK = 8'h77;
  localparam logic [7:0] SW_MASK = 8'hfe;
  localparam logic [7:0] RST_REG = 8'h00;

  localparam int NUM_IRQ = 3;
  localparam int IRQ_ACCEPT = 0;
  localparam int IRQ_WAKE = 1;
  localparam int IRQ_LOST = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_OFFER = 2'b10
  } vec_state_t;

  typedef struct packed {
    logic valid;
    logic [5:0] code;
    logic [PRIO_W-1:0] prio;
    logic [15:0] addr;
  } vec_t;

  typedef struct packed {
    vec_state_t st;
    vec_t vec;
    logic [7:0] en_lo;
    logic [7:0] en_hi;
    logic [NUM_PREG-1:0][7:0] prio;
    logic [7:0] sw_req;
    logic [7:0] sw_en;
    logic [1:0] level;
    logic [NUM_IRQ-1:0] stat;
    logic [NUM_IRQ-1:0] mask;
    logic rst_pend;
    logic [NUM_HWT-1:0] hwt_pend;
    logic [NUM_TRAP-1:0] trap_pend;
    logic wake;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [7:0] w_byte;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ctl_state_t;
endpackage : ivec_pkg

// >>> core/prio_pick.sv
module prio_pick #(
  parameter int N = 16,
  parameter int W = 4
) (
  input wire logic [N-1:0] req,
  input wire logic [N-1:0][W-1:0] prio,
  output logic any,
  output logic [$clog2(N)-1:0] idx,
  output logic [W-1:0] best
);
  always_comb begin
    any = 1'b0;
    idx = '0;
    best = '0;
    for (int i = 0; i < N; i++) begin
      if (req[i] && (!any || prio[i] > best)) begin
        any = 1'b1;
        idx = ($clog2(N))'(i);
        best = prio[i];
      end
    end
  end
endmodule : prio_pick

// >>> core/event_interrupt_vectoring.sv
// Chosen here: the AXI4-Lite register port and the placing of the registers.
module event_interrupt_vectoring (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [ivec_pkg::NUM_EVT-1:0] evt_flags,
  input wire logic timer2_external_flag,
  input wire logic reset_req,
  input wire logic [ivec_pkg::NUM_HWT-1:0] hw_trap,
  input wire logic trap_insn_valid,
  input wire logic [3:0] trap_insn_num,
  input wire logic [ivec_pkg::PRIO_W-1:0] core_priority,
  input wire logic idle_mode,
  input wire logic power_down,
  output ivec_pkg::vec_t vec,
  input wire logic vec_ready,
  output logic wake,
  output logic irq
);
  import ivec_pkg::*;

  ctl_state_t q, d;
  logic [NUM_EVT-1:0] flags;
  logic [NUM_EVT-1:0] evt_en;
  logic gie;
  logic [NUM_MASKABLE-1:0] cand_req;
  logic [NUM_MASKABLE-1:0][PRIO_W-1:0] cand_prio;
  logic m_any;
  logic [3:0] m_idx;
  logic [PRIO_W-1:0] m_prio;
  logic m_ok;
  logic exc_any;
  vec_t exc_vec;
  vec_t msk_vec;
  logic wake_c;
  logic [31:0] rd_data;
  logic rd_ok;
  logic [2:0] fld;

  assign gie = q.en_lo[GIE_BIT];
  assign evt_en = {q.en_hi[3:0], q.en_lo[4:0]};

  always_comb begin
    flags = evt_flags;
    flags[EVT_TIMER2] = evt_flags[EVT_TIMER2] | timer2_external_flag;
  end

  // Candidate list: events first (ranks 2..10), then software requests
  always_comb begin
    fld = '0;
    cand_req = '0;
    cand_prio = '0;
    for (int i = 0; i < NUM_EVT; i++) begin
      fld = EVT_PHI[i] ? q.prio[EVT_PREG[i]][PRIO_HI_LSB +: 3]
                       : q.prio[EVT_PREG[i]][PRIO_LO_LSB +: 3];
      cand_req[i] = flags[i] & evt_en[i] & gie;
      cand_prio[i] = (fld == 3'h0) ? 4'h0 : {1'b1, fld};
    end
    for (int j = 0; j < NUM_SW; j++) begin
      cand_req[NUM_EVT+j] = q.sw_req[j+1] & q.sw_en[j+1];
      cand_prio[NUM_EVT+j] = PRIO_W'(j + 1);
    end
  end

  prio_pick #(.N(NUM_MASKABLE), .W(PRIO_W)) u_pick (
    .req(cand_req),
    .prio(cand_prio),
    .any(m_any),
    .idx(m_idx),
    .best(m_prio)
  );

  assign m_ok = m_any && (m_prio > core_priority);

  always_comb begin
    msk_vec = '0;
    msk_vec.valid = 1'b1;
    msk_vec.prio = m_prio;
    if (int'(m_idx) < NUM_EVT) begin
      msk_vec.code = 6'(CODE_EVT + int'(m_idx));
      msk_vec.addr = EVT_VEC[m_idx];
    end else begin
      msk_vec.code = 6'(CODE_SW + int'(m_idx) - NUM_EVT);
      msk_vec.addr = VEC_SW_BASE
        + 16'(VEC_STEP * (int'(m_idx) - NUM_EVT));
    end
  end

  // Exceptions and traps ignore masks; later hits take precedence
  always_comb begin
    exc_any = 1'b0;
    exc_vec = '0;
    exc_vec.valid = 1'b1;
    for (int k = NUM_TRAP - 1; k >= 0; k--) begin
      if (q.trap_pend[k]) begin
        exc_any = 1'b1;
        exc_vec.code = 6'(CODE_TRAP + k);
        exc_vec.addr = VEC_TRAP_BASE + 16'(VEC_STEP * k);
      end
    end
    for (int k = NUM_HWT - 1; k >= 0; k--) begin
      if (q.hwt_pend[k]) begin
        exc_any = 1'b1;
        exc_vec.code = 6'(CODE_HWT + k);
        exc_vec.addr = VEC_HWT_BASE + 16'(VEC_STEP * k);
      end
    end
    if (q.rst_pend) begin
      exc_any = 1'b1;
      exc_vec.code = 6'(CODE_RESET);
      exc_vec.addr = VEC_RESET;
    end
  end

  always_comb begin
    wake_c = idle_mode && (exc_any || m_ok);
    if (power_down && gie
        && ((flags[EVT_EXT0] && evt_en[EVT_EXT0] && q.level[0])
        || (flags[EVT_EXT1] && evt_en[EVT_EXT1] && q.level[1]))) begin
      wake_c = 1'b1;
    end
  end

  // Register read decode
  always_comb begin
    rd_data = '0;
    rd_ok = 1'b1;
    if (araddr[7:5] == 3'h0 && araddr[4:2] >= 3'h2) begin
      rd_data[7:0] = q.prio[araddr[4:2] - 3'h2];
    end else begin
      unique case ({araddr[7:2], 2'b00})
        OFF_EN_LO: rd_data[7:0] = q.en_lo;
        OFF_EN_HI: rd_data[7:0] = q.en_hi;
        OFF_SW_REQ: rd_data[7:0] = q.sw_req;
        OFF_SW_EN: rd_data[7:0] = q.sw_en;
        OFF_LEVEL: rd_data[1:0] = q.level;
        OFF_STAT: rd_data[NUM_IRQ-1:0] = q.stat;
        OFF_MASK: rd_data[NUM_IRQ-1:0] = q.mask;
        OFF_VEC: rd_data = {q.vec.valid, 9'h000, q.vec.code, q.vec.addr};
        default: rd_ok = 1'b0;
      endcase
    end
  end

  always_comb begin
    d = q;
    // Vector handshake toward the core
    unique case (q.st)
      S_IDLE: begin
        if (exc_any) begin
          d.vec = exc_vec;
          d.st = S_OFFER;
        end else if (m_ok) begin
          d.vec = msk_vec;
          d.st = S_OFFER;
        end
      end
      S_OFFER: begin
        if (vec_ready) begin
          d.vec.valid = 1'b0;
          d.st = S_IDLE;
          if (int'(q.vec.code) == CODE_RESET) begin
            d.rst_pend = 1'b0;
          end else if (int'(q.vec.code) < CODE_TRAP) begin
            d.hwt_pend[int'(q.vec.code) - CODE_HWT] = 1'b0;
          end else if (int'(q.vec.code) < CODE_EVT) begin
            d.trap_pend[int'(q.vec.code) - CODE_TRAP] = 1'b0;
          end else if (int'(q.vec.code) >= CODE_SW) begin
            d.sw_req[int'(q.vec.code) - CODE_SW + 1] = 1'b0;
          end
        end
      end
    endcase
    // New exception requests win over the clear above
    if (reset_req) begin
      d.rst_pend = 1'b1;
    end
    d.hwt_pend = d.hwt_pend | hw_trap;
    if (trap_insn_valid) begin
      d.trap_pend[trap_insn_num] = 1'b1;
    end
    // AXI4-Lite write channel
    if (awvalid && awready) begin
      d.aw_got = 1'b1;
      d.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      d.w_got = 1'b1;
      d.w_byte = wdata[7:0];
      d.w_lane0 = wstrb[0];
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      if (q.aw_addr[7:5] == 3'h0 && q.aw_addr[4:2] >= 3'h2) begin
        if (q.w_lane0) begin
          d.prio[q.aw_addr[4:2] - 3'h2] = q.w_byte & PRIO_MASK;
        end
      end else begin
        unique case ({q.aw_addr[7:2], 2'b00})
          OFF_EN_LO: if (q.w_lane0) d.en_lo = q.w_byte;
          OFF_EN_HI: if (q.w_lane0) d.en_hi = q.w_byte & EN_HI_MASK;
          OFF_SW_REQ: if (q.w_lane0) d.sw_req = q.w_byte & SW_MASK;
          OFF_SW_EN: if (q.w_lane0) d.sw_en = q.w_byte & SW_MASK;
          OFF_LEVEL: if (q.w_lane0) d.level = q.w_byte[1:0];
          OFF_STAT: if (q.w_lane0) d.stat = d.stat & ~q.w_byte[2:0];
          OFF_MASK: if (q.w_lane0) d.mask = q.w_byte[2:0];
          OFF_VEC: d.bresp = RESP_OKAY;
          default: d.bresp = RESP_SLVERR;
        endcase
      end
    end
    // AXI4-Lite read channel
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      d.rvalid = 1'b1;
      d.rdata = rd_data;
      d.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    // Sticky events are set after the clear so a set is never lost
    if (q.st == S_OFFER && vec_ready) begin
      d.stat[IRQ_ACCEPT] = 1'b1;
    end
    d.wake = wake_c;
    if (wake_c && !q.wake) begin
      d.stat[IRQ_WAKE] = 1'b1;
    end
    if (|(hw_trap & q.hwt_pend)
        || (trap_insn_valid && q.trap_pend[trap_insn_num])) begin
      d.stat[IRQ_LOST] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.st <= S_IDLE;
      q.en_lo <= RST_REG;
      q.en_hi <= RST_REG;
      q.sw_req <= RST_REG;
      q.sw_en <= RST_REG;
      q.rst_pend <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign awready = !q.aw_got && !q.bvalid;
  assign wready = !q.w_got && !q.bvalid;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = !q.rvalid;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign vec = q.vec;
  assign wake = q.wake;
  assign irq = |(q.stat & q.mask);

  a_vec_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    vec.valid && !vec_ready |=> vec.valid && $stable(vec.addr)
      && $stable(vec.code))
    else $error("vector changed before it was taken");

  a_vec_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    vec.valid && vec_ready |=> !vec.valid)
    else $error("vector still offered after it was taken");

  a_acc_status: assert property (@(posedge aclk) disable iff (!aresetn)
    vec.valid && vec_ready |=> q.stat[IRQ_ACCEPT])
    else $error("accepted vector did not set status");

  a_reset_first: assert property (@(posedge aclk) disable iff (!aresetn)
    q.st == S_IDLE && q.rst_pend |=> vec.valid
      && vec.addr == 16'h0000 && vec.code == 6'h00)
    else $error("pending reset did not vector to zero");

  a_hwt_addr: assert property (@(posedge aclk) disable iff (!aresetn)
    vec.valid && vec.code >= 6'h01 && vec.code <= 6'h05
      |-> vec.addr == {8'h00, vec.code, 2'b00})
    else $error("hardware trap vector wrong");

  a_trap_addr: assert property (@(posedge aclk) disable iff (!aresetn)
    vec.valid && vec.code >= 6'h06 && vec.code <= 6'h15
      |-> vec.addr == 16'h0040 + {8'h00, vec.code - 6'h06, 2'b00})
    else $error("trap instruction vector wrong");

  a_evt_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(vec.valid) && vec.code >= 6'h16 && vec.code <= 6'h1e
      |-> $past(q.en_lo[7]) && vec.prio[3]
      && vec.prio > $past(core_priority))
    else $error("event taken while gated or too low");

  a_evt_field: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(vec.valid) && vec.code == 6'h16
      |-> vec.prio == {1'b1, $past(q.prio[0][2:0])})
    else $error("first event priority does not follow its field");

  a_evt_addr: assert property (@(posedge aclk) disable iff (!aresetn)
    vec.valid && vec.code == 6'h16 |-> vec.addr == 16'h0080)
    else $error("first event vector wrong");

  a_sw_addr: assert property (@(posedge aclk) disable iff (!aresetn)
    vec.valid && vec.code >= 6'h1f
      |-> vec.addr == 16'h0100 + {8'h00, vec.code - 6'h1f, 2'b00}
      && vec.prio == 4'(vec.code - 6'h1e))
    else $error("software vector or priority wrong");

  a_sw_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(vec.valid) && vec.code >= 6'h1f
      |-> (($past(q.sw_en) >> (vec.code - 6'h1e)) & 8'h01) == 8'h01
      && vec.prio > $past(core_priority))
    else $error("software request taken while disabled or too low");

  a_pd_wake: assert property (@(posedge aclk) disable iff (!aresetn)
    power_down && !idle_mode && !q.en_lo[7] |=> !wake)
    else $error("power-down wake without global enable");

  a_idle_wake: assert property (@(posedge aclk) disable iff (!aresetn)
    idle_mode && q.rst_pend |=> wake)
    else $error("idle mode missed a pending request");
endmodule : event_interrupt_vectoring

// >>> verification/core_model.sv
module core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire ivec_pkg::vec_t vec,
  input wire logic slow,
  input wire logic [8:0] evt_set,
  output logic vec_ready,
  output logic [8:0] evt_flags,
  output ivec_pkg::vec_t got,
  output int got_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  import ivec_pkg::*;
  logic [1:0] wait_q;
  logic [8:0] clr;

  // Flag of an event whose vector is taken is cleared by its peripheral
  always_comb begin
    clr = 9'h000;
    if (vec.code >= 6'(CODE_EVT) && vec.code < 6'(CODE_SW)) begin
      clr = 9'h001 << (vec.code - 6'(CODE_EVT));
    end
  end

  // Core takes a vector after one cycle or after a few cycles of stalling
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vec_ready <= 1'b0;
      wait_q <= 2'h0;
      evt_flags <= 9'h000;
      got <= '0;
      got_cnt <= 0;
    end else begin
      evt_flags <= evt_flags | evt_set;
      if (vec.valid && vec_ready) begin
        got <= vec;
        got_cnt <= got_cnt + 1;
        vec_ready <= 1'b0;
        wait_q <= 2'h0;
        evt_flags <= (evt_flags | evt_set) & ~clr;
      end else if (vec.valid) begin
        vec_ready <= !slow || wait_q == 2'h3;
        wait_q <= wait_q + 2'h1;
      end
    end
  end
endmodule : core_model

// >>> verification/testbench.sv
`define CHK(g, e) check(32'(g), 32'(e))
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ivec_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, slow = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0, trap_insn_num = 4'h0, core_priority = 4'h0;
  logic reset_req = 1'b0, trap_insn_valid = 1'b0, t2_ext = 1'b0;
  logic idle_mode = 1'b0, power_down = 1'b0;
  logic [4:0] hw_trap = 5'h00;
  logic [8:0] evt_set = 9'h000;
  logic awready, wready, bvalid, arready, rvalid, vec_ready, wake, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [8:0] evt_flags;
  vec_t vec, got;
  int got_cnt;
  int exp_n = 0, mismatches = 0, compares = 0;
  logic [15:0] evt_vec [9] = '{16'h0080, 16'h0084, 16'h0088, 16'h008c,
    16'h0090, 16'h00a0, 16'h00a4, 16'h00a8, 16'h00ac};

  always #4 aclk = ~aclk;

  event_interrupt_vectoring i_dut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .evt_flags(evt_flags), .timer2_external_flag(t2_ext),
    .reset_req(reset_req), .hw_trap(hw_trap),
    .trap_insn_valid(trap_insn_valid), .trap_insn_num(trap_insn_num),
    .core_priority(core_priority), .idle_mode(idle_mode),
    .power_down(power_down), .vec(vec), .vec_ready(vec_ready),
    .wake(wake), .irq(irq));

  core_model i_core (.aclk(aclk), .aresetn(aresetn), .vec(vec),
    .slow(slow), .evt_set(evt_set), .vec_ready(vec_ready),
    .evt_flags(evt_flags), .got(got), .got_cnt(got_cnt));

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check

  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d,
                        input logic [1:0] er);
    logic aw_t, w_t, b_t;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h000000, d};
    wstrb <= 4'h1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw_t = awready;
      w_t = wready;
      b_t = bvalid;
      if (b_t) `CHK(bresp, er);
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end while (!b_t);
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [7:0] ed,
                        input logic [1:0] er);
    logic ar_t, r_t;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ar_t = arready;
      r_t = rvalid;
      if (r_t) `CHK(rresp, er);
      if (r_t && er == RESP_OKAY) `CHK(rdata, {24'h000000, ed});
      @(posedge aclk);
      if (ar_t) arvalid <= 1'b0;
    end while (!r_t);
    rready <= 1'b0;
  endtask : axi_rd

  task automatic raise(input logic [8:0] f);
    @(posedge aclk);
    evt_set <= f;
    @(posedge aclk);
    evt_set <= 9'h000;
  endtask : raise

  task automatic expect_vec(input logic [15:0] a, input logic [3:0] p);
    exp_n++;
    while (got_cnt < exp_n) @(negedge aclk);
    `CHK(got.addr, a);
    `CHK(got.prio, p);
  endtask : expect_vec

  task automatic no_vec();
    repeat (20) @(negedge aclk);
    `CHK(got_cnt, exp_n);
  endtask : no_vec

  task automatic wait_wake();
    int n;
    n = 0;
    while (wake !== 1'b1 && n < 10) begin
      @(negedge aclk);
      n++;
    end
    `CHK(wake, 1'b1);
  endtask : wait_wake

  task automatic stop_test();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    stop_test();
  end

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    expect_vec(16'h0000, 4'h0);
    `CHK(got.code, 6'h00);
    `CHK(irq, 1'b0);
    axi_rd(OFF_STAT, 8'h01, RESP_OKAY);
    axi_wr(OFF_MASK, 8'h01, RESP_OKAY);
    @(negedge aclk);
    `CHK(irq, 1'b1);
    axi_wr(OFF_STAT, 8'h01, RESP_OKAY);
    @(negedge aclk);
    `CHK(irq, 1'b0);
    axi_wr(8'h3c, 8'h01, RESP_SLVERR);
    axi_rd(8'h3c, 8'h00, RESP_SLVERR);
    slow <= 1'b1;
    for (int i = 0; i < NUM_HWT; i++) begin
      @(posedge aclk);
      hw_trap <= 5'h01 << i;
      @(posedge aclk);
      hw_trap <= 5'h00;
      expect_vec(16'(16'h0004 + 4 * i), 4'h0);
    end
    slow <= 1'b0;
    for (int n = 0; n < NUM_TRAP; n++) begin
      @(posedge aclk);
      trap_insn_valid <= 1'b1;
      trap_insn_num <= 4'(n);
      @(posedge aclk);
      trap_insn_valid <= 1'b0;
      expect_vec(16'(16'h0040 + 4 * n), 4'h0);
    end
    @(posedge aclk);
    reset_req <= 1'b1;
    hw_trap <= 5'h10;
    trap_insn_valid <= 1'b1;
    trap_insn_num <= 4'h3;
    @(posedge aclk);
    reset_req <= 1'b0;
    hw_trap <= 5'h00;
    trap_insn_valid <= 1'b0;
    expect_vec(16'h0000, 4'h0);
    expect_vec(16'h0014, 4'h0);
    expect_vec(16'h004c, 4'h0);
    axi_wr(OFF_EN_LO, 8'h9f, RESP_OKAY);
    axi_wr(OFF_EN_HI, 8'h0f, RESP_OKAY);
    for (int k = 0; k < NUM_PREG; k++) begin
      axi_wr(8'(OFF_PRIO0 + 4 * k), 8'hff, RESP_OKAY);
      axi_rd(8'(OFF_PRIO0 + 4 * k), 8'h77, RESP_OKAY);
      axi_wr(8'(OFF_PRIO0 + 4 * k), 8'h11, RESP_OKAY);
    end
    raise(9'h1ff);
    for (int e = 0; e < NUM_EVT; e++) expect_vec(evt_vec[e], 4'h9);
    axi_wr(OFF_PRIO5, 8'h21, RESP_OKAY);
    raise(9'h101);
    expect_vec(16'h00ac, 4'ha);
    expect_vec(16'h0080, 4'h9);
    axi_wr(OFF_PRIO0, 8'h10, RESP_OKAY);
    raise(9'h001);
    no_vec();
    axi_wr(OFF_PRIO0, 8'h11, RESP_OKAY);
    expect_vec(16'h0080, 4'h9);
    axi_wr(OFF_EN_LO, 8'h1f, RESP_OKAY);
    raise(9'h002);
    no_vec();
    axi_wr(OFF_EN_LO, 8'h9d, RESP_OKAY);
    no_vec();
    axi_wr(OFF_EN_LO, 8'h9f, RESP_OKAY);
    expect_vec(16'h0084, 4'h9);
    @(posedge aclk);
    t2_ext <= 1'b1;
    repeat (2) @(posedge aclk);
    t2_ext <= 1'b0;
    expect_vec(16'h0090, 4'h9);
    @(posedge aclk);
    core_priority <= 4'h9;
    raise(9'h004);
    no_vec();
    @(posedge aclk);
    core_priority <= 4'h8;
    expect_vec(16'h0088, 4'h9);
    @(posedge aclk);
    core_priority <= 4'h0;
    axi_wr(OFF_SW_REQ, 8'h02, RESP_OKAY);
    no_vec();
    axi_wr(OFF_SW_EN, 8'hfe, RESP_OKAY);
    expect_vec(16'h0100, 4'h1);
    for (int k = 2; k <= NUM_SW; k++) begin
      axi_wr(OFF_SW_REQ, 8'h01 << k, RESP_OKAY);
      expect_vec(16'(16'h0100 + 4 * (k - 1)), 4'(k));
    end
    axi_rd(OFF_SW_REQ, 8'h00, RESP_OKAY);
    @(posedge aclk);
    slow <= 1'b1;
    idle_mode <= 1'b1;
    reset_req <= 1'b1;
    raise(9'h008);
    reset_req <= 1'b0;
    wait_wake();
    expect_vec(16'h0000, 4'h0);
    expect_vec(16'h008c, 4'h9);
    @(posedge aclk);
    idle_mode <= 1'b0;
    slow <= 1'b0;
    core_priority <= 4'hf;
    power_down <= 1'b1;
    raise(9'h004);
    repeat (10) @(negedge aclk);
    `CHK(wake, 1'b0);
    axi_wr(OFF_LEVEL, 8'h02, RESP_OKAY);
    wait_wake();
    axi_wr(OFF_EN_LO, 8'h1f, RESP_OKAY);
    @(negedge aclk);
    `CHK(wake, 1'b0);
    axi_wr(OFF_EN_LO, 8'h9f, RESP_OKAY);
    wait_wake();
    @(posedge aclk);
    power_down <= 1'b0;
    core_priority <= 4'h0;
    expect_vec(16'h0088, 4'h9);
    no_vec();
    stop_test();
  end
endmodule : testbench
